// ==== rtl/bert_error_insert_and_monitor.sv ====
// Summary of operation
// - Rate field n inverts one bit per 10^n
// - Nonzero rate write starts rate insertion
// - Rewrite takes effect after next rate-inserted error
// - Single errors only while single enable set
// - Register trigger rise inverts one bit
// - Several toggles between opportunities give one error
// - Source select picks register or pin trigger
// - Update status rises done, drops with trigger
// - Nonzero status follows error count
// - Unlocked status follows pattern sync state
// - Update latched on status rise, read clears
// - Bit error latched on mismatch, read clears
// - Nonzero latched on rise, read clears
// - Unlocked latched on any change, read clears
// - Each latched flag has own enable
// - Error count 24 bits, saturating
// - Error count holds while unlocked
// - Bit count 32 bits, saturating
// - Bit count holds while unlocked
// - Second group copy sits 20h higher
// - Update rise snapshots counts, restarts counters
// - Six mismatches in 64 bits request resync
module bert_error_insert_and_monitor
    import bert_pkg::*;
#(
    parameter logic GROUP = 1'b0
)
(
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    input  wire logic [5:0] ADDR,
    input  wire logic       WR_EN,
    input  wire logic [7:0] WDATA,
    input  wire logic       RD_EN,
    output logic      [7:0] RDATA,
    input  wire logic       TX_IN_VALID,
    input  wire logic       TX_IN_BIT,
    output logic            TX_IN_READY,
    output logic            TX_OUT_VALID,
    output logic            TX_OUT_BIT,
    input  wire logic       TX_OUT_READY,
    input  wire logic       EXTERNAL_ERROR_TRIGGER_PIN,
    input  wire logic       EXTERNAL_UPDATE_REQUEST_PIN,
    input  wire logic       RX_VALID,
    input  wire logic       RX_BIT,
    input  wire logic       RX_EXPECTED_BIT,
    input  wire logic       RX_PATTERN_UNLOCKED,
    input  wire logic       AUTO_RESYNC_DISABLE,
    output logic            RESYNC_REQ,
    output logic            IRQ
);

    // Group base address
    localparam logic [5:0] BASE = GROUP ? GROUP_STRIDE : 6'h00;

    st_s st_reg;                    // Registered state
    st_s st_next;                   // Next state
    logic       err_trig;           // Selected single-error trigger
    logic       upd_trig;           // Selected update trigger
    logic       push;               // Transmit bit accepted
    logic       pop;                // Transmit bit delivered
    logic       rate_hit;           // Rate period ends on this bit
    logic       flip;               // Invert the accepted bit
    logic       tx_bit;             // Accepted bit after insertion
    logic       rx_err;             // Counted mismatch
    logic       rx_count;           // Counted bit
    logic       nz;                 // Live error count nonzero
    logic       upd_rise;           // Update trigger edge
    logic [3:0] live;               // Live status bits
    logic [3:0] set;                // Latched flag sets
    logic [2:0] new_rate;           // Rate field being written

    // Decode one register in this group
    function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
        return a == (ofs | BASE);
    endfunction

    // All next-state logic
    always_comb
    begin
        st_next = st_reg;
        // Pins pass two flops before use
        st_next.err_s1 = EXTERNAL_ERROR_TRIGGER_PIN;
        st_next.err_s2 = st_reg.err_s1;
        st_next.upd_s1 = EXTERNAL_UPDATE_REQUEST_PIN;
        st_next.upd_s2 = st_reg.upd_s1;
        st_next.resync = 1'b0;
        new_rate = WDATA[B_RATE_LO +: RATE_W];

        // Trigger source select
        err_trig = st_reg.err_ctrl[B_SRC_SEL] ? st_reg.err_s2
                                               : st_reg.err_ctrl[B_SINGLE_TRIG];
        upd_trig = st_reg.upd_ctrl[B_UPD_SEL] ? st_reg.upd_s2
                                               : st_reg.upd_ctrl[B_UPD_LOCAL];
        st_next.trig_prev = err_trig;
        st_next.upd_prev  = upd_trig;
        upd_rise = upd_trig && !st_reg.upd_prev;

        // Buffer handshakes
        push = TX_IN_VALID && (st_reg.buf_cnt != 2'h2);
        pop  = TX_OUT_READY && (st_reg.buf_cnt != 2'h0);

        // Rate and single insertion on accepted bits
        rate_hit = (st_reg.rate_cur != 3'h0)
                && (st_reg.rate_cnt == decade_last(st_reg.rate_cur));
        flip   = push && (rate_hit || st_reg.armed);
        tx_bit = TX_IN_BIT ^ flip;
        if (push)
        begin
            // Armed request is consumed by one bit only
            st_next.armed = 1'b0;
            if (rate_hit)
            begin
                st_next.rate_cnt = '0;
                // Pending rewrite lands after this error
                if (st_reg.pend)
                begin
                    st_next.rate_cur = st_reg.rate_pend;
                    st_next.pend     = 1'b0;
                end
            end
            else if (st_reg.rate_cur != 3'h0)
            begin
                st_next.rate_cnt = st_reg.rate_cnt + 24'h000001;
            end
        end

        // Single error arming; a new edge beats consumption
        if (!st_reg.err_ctrl[B_SINGLE_EN])
        begin
            st_next.armed = 1'b0;
        end
        else if (err_trig && !st_reg.trig_prev)
        begin
            st_next.armed = 1'b1;
        end

        // Register writes
        if (WR_EN && hit(ADDR, OFS_ERR_CTRL))
        begin
            st_next.err_ctrl = WDATA;
            if (st_reg.rate_cur == 3'h0)
            begin
                // Idle: start at once, period counted from here
                st_next.rate_cur = new_rate;
                st_next.rate_cnt = '0;
            end
            else
            begin
                // Busy: hold until the next rate error goes out
                st_next.rate_pend = new_rate;
                st_next.pend      = 1'b1;
            end
        end
        if (WR_EN && hit(ADDR, OFS_UPD_CTRL))
        begin
            st_next.upd_ctrl = WDATA;
        end
        if (WR_EN && hit(ADDR, OFS_IE))
        begin
            st_next.ie = WDATA[3:0];
        end

        // Transmit two-entry buffer, head in entry zero
        case ({push, pop})
            2'b10:
            begin
                st_next.buf_bit[st_reg.buf_cnt[0]] = tx_bit;
                st_next.buf_cnt = st_reg.buf_cnt + 2'h1;
            end
            2'b01:
            begin
                st_next.buf_bit[0] = st_reg.buf_bit[1];
                st_next.buf_cnt = st_reg.buf_cnt - 2'h1;
            end
            2'b11:
            begin
                // Count stays; shift and refill
                if (st_reg.buf_cnt == 2'h1)
                begin
                    st_next.buf_bit[0] = tx_bit;
                end
                else
                begin
                    st_next.buf_bit[0] = st_reg.buf_bit[1];
                    st_next.buf_bit[1] = tx_bit;
                end
            end
            default:
            begin
                st_next.buf_cnt = st_reg.buf_cnt;
            end
        endcase

        // Receive counting, frozen while unlocked
        rx_count = RX_VALID && !RX_PATTERN_UNLOCKED;
        rx_err   = rx_count && (RX_BIT != RX_EXPECTED_BIT);
        if (rx_count && (st_reg.bit_cnt != BIT_MAX))
        begin
            st_next.bit_cnt = st_reg.bit_cnt + 32'h00000001;
        end
        if (rx_err && (st_reg.err_cnt != ERR_MAX))
        begin
            st_next.err_cnt = st_reg.err_cnt + 24'h000001;
        end

        // Update: snapshot and restart, same-cycle bit counts
        if (upd_rise)
        begin
            st_next.err_snap = st_reg.err_cnt;
            st_next.bit_snap = st_reg.bit_cnt;
            st_next.err_cnt  = {{(ERR_W-1){1'b0}}, rx_err};
            st_next.bit_cnt  = {{(BIT_W-1){1'b0}}, rx_count};
            st_next.upd_done = 1'b1;
        end
        if (!upd_trig)
        begin
            st_next.upd_done = 1'b0;
        end

        // Mismatch window for automatic resync
        if (RX_PATTERN_UNLOCKED)
        begin
            st_next.win_cnt = '0;
            st_next.mis_cnt = '0;
        end
        else if (RX_VALID)
        begin
            st_next.win_cnt = st_reg.win_cnt + 6'h01;
            if (rx_err && (st_reg.mis_cnt == MIS_TRIP) && !AUTO_RESYNC_DISABLE)
            begin
                st_next.resync = 1'b1;
            end
            if (st_reg.win_cnt == WIN_LAST)
            begin
                st_next.mis_cnt = '0;
            end
            else if (rx_err && (st_reg.mis_cnt <= MIS_TRIP))
            begin
                st_next.mis_cnt = st_reg.mis_cnt + 3'h1;
            end
        end

        // Live status; update bit drops as soon as trigger does
        nz = st_reg.err_cnt != '0;
        live[F_OOS] = RX_PATTERN_UNLOCKED;
        live[F_NZ]  = nz;
        live[F_BE]  = 1'b0;
        live[F_UPD] = st_reg.upd_done && upd_trig;
        st_next.oos_prev = RX_PATTERN_UNLOCKED;
        st_next.nz_prev  = nz;

        // Latched flag sets
        set[F_UPD] = st_next.upd_done && !st_reg.upd_done;
        set[F_BE]  = rx_err;
        set[F_NZ]  = nz && !st_reg.nz_prev;
        set[F_OOS] = RX_PATTERN_UNLOCKED != st_reg.oos_prev;

        // Read data, registered; unmapped reads zero
        if (RD_EN)
        begin
            st_next.rdata = 8'h00;
            if (hit(ADDR, OFS_ERR_CTRL)) st_next.rdata = st_reg.err_ctrl;
            if (hit(ADDR, OFS_UPD_CTRL)) st_next.rdata = st_reg.upd_ctrl;
            if (hit(ADDR, OFS_LIVE))     st_next.rdata = {4'h0, live};
            if (hit(ADDR, OFS_LATCH))    st_next.rdata = {4'h0, st_reg.latched};
            if (hit(ADDR, OFS_IE))       st_next.rdata = {4'h0, st_reg.ie};
            if (hit(ADDR, OFS_EC0))      st_next.rdata = st_reg.err_snap[7:0];
            if (hit(ADDR, OFS_EC1))      st_next.rdata = st_reg.err_snap[15:8];
            if (hit(ADDR, OFS_EC2))      st_next.rdata = st_reg.err_snap[23:16];
            if (hit(ADDR, OFS_BC0))      st_next.rdata = st_reg.bit_snap[7:0];
            if (hit(ADDR, OFS_BC1))      st_next.rdata = st_reg.bit_snap[15:8];
            if (hit(ADDR, OFS_BC2))      st_next.rdata = st_reg.bit_snap[23:16];
            if (hit(ADDR, OFS_BC3))      st_next.rdata = st_reg.bit_snap[31:24];
            // Read clears, but a set in the same cycle survives
            if (hit(ADDR, OFS_LATCH))
            begin
                st_next.latched = 4'h0;
            end
        end
        st_next.latched = st_next.latched | set;

        // Interrupt from enabled latched flags
        st_next.irq = |(st_next.latched & st_next.ie);
    end

    // State register, synchronous reset
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            st_reg <= ST_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign RDATA        = st_reg.rdata;
    assign TX_IN_READY  = st_reg.buf_cnt != 2'h2;
    assign TX_OUT_VALID = st_reg.buf_cnt != 2'h0;
    assign TX_OUT_BIT   = st_reg.buf_bit[0];
    assign RESYNC_REQ   = st_reg.resync;
    assign IRQ          = st_reg.irq;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    a_rate_tenth: assert property (
        push && st_reg.rate_cur == 3'h1 && st_reg.rate_cnt == 24'h000009
        |-> flip)
        else $error("tenth bit not inverted");

    a_single_masked: assert property (
        !st_reg.err_ctrl[B_SINGLE_EN] |=> !st_reg.armed)
        else $error("single error armed while disabled");

    a_upd_drop: assert property (
        !upd_trig |=> !st_reg.upd_done)
        else $error("update status held without trigger");

    a_oos_latch: assert property (
        $changed(RX_PATTERN_UNLOCKED) |=> st_reg.latched[F_OOS])
        else $error("sync change not latched");

    a_err_freeze: assert property (
        RX_PATTERN_UNLOCKED && !upd_rise |=> $stable(st_reg.err_cnt))
        else $error("error count moved while unlocked");

    a_bit_freeze: assert property (
        RX_PATTERN_UNLOCKED && !upd_rise |=> $stable(st_reg.bit_cnt))
        else $error("bit count moved while unlocked");

    a_err_saturate: assert property (
        st_reg.err_cnt == ERR_MAX && !upd_rise |=> st_reg.err_cnt == ERR_MAX)
        else $error("error count wrapped");

    a_bit_saturate: assert property (
        st_reg.bit_cnt == BIT_MAX && !upd_rise |=> st_reg.bit_cnt == BIT_MAX)
        else $error("bit count wrapped");

    a_irq_follow: assert property (
        IRQ == |(st_reg.latched & st_reg.ie))
        else $error("interrupt does not follow enabled flags");

    c_rate_insert: cover property (flip && rate_hit);
    c_single_insert: cover property (flip && !rate_hit);
    c_update: cover property (upd_rise ##1 st_reg.upd_done);
    c_resync: cover property (RESYNC_REQ);

endmodule

// ==== rtl/bert_pkg.sv ====
package bert_pkg;

    // Register offsets inside one channel group
    localparam logic [5:0] OFS_UPD_CTRL = 6'h01;
    localparam logic [5:0] OFS_ERR_CTRL = 6'h08;
    localparam logic [5:0] OFS_LIVE     = 6'h0C;
    localparam logic [5:0] OFS_LATCH    = 6'h0E;
    localparam logic [5:0] OFS_IE       = 6'h10;
    localparam logic [5:0] OFS_EC0      = 6'h14;
    localparam logic [5:0] OFS_EC1      = 6'h15;
    localparam logic [5:0] OFS_EC2      = 6'h16;
    localparam logic [5:0] OFS_BC0      = 6'h18;
    localparam logic [5:0] OFS_BC1      = 6'h19;
    localparam logic [5:0] OFS_BC2      = 6'h1A;
    localparam logic [5:0] OFS_BC3      = 6'h1B;
    // Second channel group sits this far above the first
    localparam logic [5:0] GROUP_STRIDE = 6'h20;

    // Error insertion control fields
    localparam int B_SRC_SEL     = 0;
    localparam int B_SINGLE_TRIG = 1;
    localparam int B_SINGLE_EN   = 2;
    localparam int B_RATE_LO     = 3;
    localparam int RATE_W        = 3;
    // Update control fields
    localparam int B_UPD_LOCAL   = 6;
    localparam int B_UPD_SEL     = 7;
    // Status flag positions
    localparam int F_OOS = 0;
    localparam int F_NZ  = 1;
    localparam int F_BE  = 2;
    localparam int F_UPD = 3;

    // Counter widths and limits
    localparam int ERR_W = 24;
    localparam int BIT_W = 32;
    localparam logic [ERR_W-1:0] ERR_MAX = 24'hFFFFFF;
    localparam logic [BIT_W-1:0] BIT_MAX = 32'hFFFFFFFF;
    // Resync window: 64 bits, trip on the sixth mismatch
    localparam logic [5:0] WIN_LAST = 6'h3F;
    localparam logic [2:0] MIS_TRIP = 3'h5;

    // Complete block state
    typedef struct packed {
        logic [7:0]       err_ctrl;
        logic [7:0]       upd_ctrl;
        logic [3:0]       ie;
        logic [3:0]       latched;
        logic [2:0]       rate_cur;
        logic [2:0]       rate_pend;
        logic             pend;
        logic [23:0]      rate_cnt;
        logic             trig_prev;
        logic             armed;
        logic             err_s1;
        logic             err_s2;
        logic             upd_s1;
        logic             upd_s2;
        logic             upd_prev;
        logic             upd_done;
        logic [ERR_W-1:0] err_cnt;
        logic [BIT_W-1:0] bit_cnt;
        logic [ERR_W-1:0] err_snap;
        logic [BIT_W-1:0] bit_snap;
        logic             oos_prev;
        logic             nz_prev;
        logic [5:0]       win_cnt;
        logic [2:0]       mis_cnt;
        logic             resync;
        logic [1:0]       buf_bit;
        logic [1:0]       buf_cnt;
        logic [7:0]       rdata;
        logic             irq;
    } st_s;

    localparam st_s ST_RESET = '0;

    // Last bit index of a 10^n period
    function automatic logic [23:0] decade_last(input logic [2:0] n);
        case (n)
            3'h1:    return 24'h000009;
            3'h2:    return 24'h000063;
            3'h3:    return 24'h0003E7;
            3'h4:    return 24'h00270F;
            3'h5:    return 24'h01869F;
            3'h6:    return 24'h0F423F;
            3'h7:    return 24'h98967F;
            default: return 24'h000000;
        endcase
    endfunction

endpackage

// ==== verification/bert_error_insert_and_monitor_bench.sv ====
module bert_error_insert_and_monitor_bench import bert_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, reset_n, wr_en, rd_en, err_pin, upd_pin;  // Clock, reset, strobes, pins
    logic [5:0]  addr;                                          // Register address
    logic [7:0]  wdata, rdata, rv;                              // Bus data, last read value
    logic        tx_in_valid, tx_in_ready, tx_out_valid, tx_out_bit, tx_out_ready;
    logic        rx_valid, rx_bit, rx_exp, unlocked, no_resync, resync, irq;
    logic        stall, flip, tx_in_bit;                        // Partner controls, data bit
    logic [23:0] ec;                                            // Snapshot error count
    logic [31:0] bc;                                            // Snapshot bit count
    int          ones, bits, errors, samples_checked, resyncs;

    bert_error_insert_and_monitor bert_error_insert_and_monitor_inst (
        .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WR_EN(wr_en), .WDATA(wdata),
        .RD_EN(rd_en), .RDATA(rdata), .TX_IN_VALID(tx_in_valid), .TX_IN_BIT(tx_in_bit),
        .TX_IN_READY(tx_in_ready), .TX_OUT_VALID(tx_out_valid), .TX_OUT_BIT(tx_out_bit),
        .TX_OUT_READY(tx_out_ready), .EXTERNAL_ERROR_TRIGGER_PIN(err_pin),
        .EXTERNAL_UPDATE_REQUEST_PIN(upd_pin), .RX_VALID(rx_valid), .RX_BIT(rx_bit),
        .RX_EXPECTED_BIT(rx_exp), .RX_PATTERN_UNLOCKED(unlocked),
        .AUTO_RESYNC_DISABLE(no_resync), .RESYNC_REQ(resync), .IRQ(irq));

    framer_model framer_model_inst (
        .clk(clk), .stall(stall), .flip(flip), .tx_valid(tx_out_valid),
        .tx_bit(tx_out_bit), .tx_ready(tx_out_ready), .rx_valid(rx_valid),
        .rx_bit(rx_bit), .rx_expected(rx_exp), .ones(ones), .bits(bits));

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Resync pulses last one cycle, so sample each one at the falling edge
    always @(negedge clk)
        if (resync === 1'b1)
            resyncs++;

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // One-cycle bus strobes, held across the taking edge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        addr  = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask

    task automatic rd(input logic [5:0] a);
        @(negedge clk);
        addr  = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        rv    = rdata;
    endtask

    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        rd(a);
        check(rv, e);
    endtask

    // Push n bits of tx_in_bit, then check how many ones came out
    task automatic send(input int n, input int exp_ones);
        int k;
        int t;
        int o;
        k = 0;
        t = 0;
        o = ones;
        @(negedge clk);
        tx_in_valid = 1'b1;
        while (k < n)
        begin
            if (tx_in_ready === 1'b1)
                k++;
            t++;
            if (t > 500)
            begin
                errors++;
                test_done();
            end
            @(negedge clk);
        end
        tx_in_valid = 1'b0;
        repeat (4) @(negedge clk);
        check(ones - o, exp_ones);
    endtask

    // Local update: snapshot counts, then read all count bytes
    task automatic update_counts();
        wr(OFS_UPD_CTRL, 8'h40);
        repeat (3) @(negedge clk);
        rdc(OFS_LIVE, 8'h08);
        wr(OFS_UPD_CTRL, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            rd(OFS_EC0 + 6'(i));
            ec[8*i +: 8] = rv;
        end
        for (int i = 0; i < 4; i++)
        begin
            rd(OFS_BC0 + 6'(i));
            bc[8*i +: 8] = rv;
        end
    endtask

    task automatic reset_regs();
        rdc(OFS_LIVE, 8'h00);
        rdc(OFS_LATCH, 8'h00);
        rdc(OFS_EC2, 8'h00);
        rdc(OFS_BC3, 8'h00);
        rdc(6'h3F, 8'h00);
        wr(OFS_IE, 8'h0F);
        rdc(OFS_IE, 8'h0F);
        wr(OFS_IE + GROUP_STRIDE, 8'h00);
        rdc(OFS_IE, 8'h0F);
        wr(OFS_IE, 8'h00);
    endtask

    task automatic rate_insertion();
        wr(OFS_ERR_CTRL, 8'h08);
        send(30, 3);
        wr(OFS_ERR_CTRL, 8'h00);
        send(20, 1);
        send(20, 0);
        wr(OFS_ERR_CTRL, 8'h10);
        send(100, 1);
        wr(OFS_ERR_CTRL, 8'h00);
        send(100, 1);
        update_counts();
        check(ec, 24'h000006);
        check(bc, 32'h0000010E);
        rdc(OFS_LATCH, 8'h0E);
        rdc(OFS_LATCH, 8'h00);
        rdc(OFS_LIVE, 8'h00);
    endtask

    task automatic single_errors();
        wr(OFS_ERR_CTRL, 8'h02);
        wr(OFS_ERR_CTRL, 8'h00);
        send(10, 0);
        wr(OFS_ERR_CTRL, 8'h04);
        wr(OFS_ERR_CTRL, 8'h06);
        wr(OFS_ERR_CTRL, 8'h04);
        wr(OFS_ERR_CTRL, 8'h06);
        send(10, 1);
        wr(OFS_ERR_CTRL, 8'h04);
        send(10, 0);
        // Source changes only while both triggers are low
        wr(OFS_ERR_CTRL, 8'h05);
        err_pin = 1'b1;
        repeat (5) @(negedge clk);
        err_pin = 1'b0;
        send(10, 1);
        wr(OFS_ERR_CTRL, 8'h07);
        wr(OFS_ERR_CTRL, 8'h05);
        send(10, 0);
        wr(OFS_ERR_CTRL, 8'h00);
        rdc(OFS_LIVE, 8'h02);
    endtask

    task automatic status_and_irq();
        rdc(OFS_LATCH, 8'h06);
        wr(OFS_IE, 8'h04);
        wr(OFS_ERR_CTRL, 8'h04);
        wr(OFS_ERR_CTRL, 8'h06);
        send(10, 1);
        check(irq, 1'b1);
        rdc(OFS_LATCH, 8'h04);
        @(negedge clk);
        check(irq, 1'b0);
        wr(OFS_IE, 8'h00);
        wr(OFS_ERR_CTRL, 8'h04);
        wr(OFS_ERR_CTRL, 8'h06);
        send(10, 1);
        check(irq, 1'b0);
        wr(OFS_ERR_CTRL, 8'h00);
        rdc(OFS_LATCH, 8'h04);
        unlocked = 1'b1;
        repeat (2) @(negedge clk);
        rdc(OFS_LIVE, 8'h03);
        wr(OFS_ERR_CTRL, 8'h08);
        send(30, 3);
        wr(OFS_ERR_CTRL, 8'h00);
        send(10, 1);
        unlocked = 1'b0;
        repeat (2) @(negedge clk);
        rdc(OFS_LATCH, 8'h01);
        update_counts();
        check(ec, 24'h000004);
        check(bc, 32'h00000046);
        // Pin-driven update: status follows the pin trigger
        wr(OFS_UPD_CTRL, 8'h80);
        upd_pin = 1'b1;
        repeat (5) @(negedge clk);
        rdc(OFS_LIVE, 8'h08);
        upd_pin = 1'b0;
        repeat (4) @(negedge clk);
        rdc(OFS_LIVE, 8'h00);
        wr(OFS_UPD_CTRL, 8'h00);
    endtask

    task automatic resync_and_buffer();
        int b;
        flip    = 1'b1;
        resyncs = 0;
        send(20, 0);
        check(resyncs > 0, 1'b1);
        // Restart the window, so only the disable can hold the request back
        unlocked = 1'b1;
        @(negedge clk);
        unlocked  = 1'b0;
        no_resync = 1'b1;
        resyncs   = 0;
        send(20, 0);
        check(resyncs, 0);
        flip  = 1'b0;
        // Stalled receiver: buffer takes two bits and refuses the rest
        stall = 1'b1;
        b     = bits;
        @(negedge clk);
        tx_in_valid = 1'b1;
        repeat (4) @(negedge clk);
        check(tx_in_ready, 1'b0);
        check(tx_out_valid, 1'b1);
        tx_in_valid = 1'b0;
        stall       = 1'b0;
        repeat (4) @(negedge clk);
        check(bits - b, 2);
        check(tx_out_valid, 1'b0);
        // Ones data: an inserted error must clear the bit, not force it high
        tx_in_bit = 1'b1;
        wr(OFS_ERR_CTRL, 8'h04);
        wr(OFS_ERR_CTRL, 8'h06);
        send(10, 9);
    endtask

    // Bound on the whole run
    initial
    begin
        repeat (100000) @(posedge clk);
        errors++;
        test_done();
    end

    initial
    begin
        {reset_n, wr_en, rd_en, err_pin, upd_pin, tx_in_valid} = '0;
        {unlocked, no_resync, stall, flip, tx_in_bit, addr, wdata} = '0;
        errors          = 0;
        samples_checked = 0;
        resyncs         = 0;
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        reset_regs();
        rate_insertion();
        single_errors();
        status_and_irq();
        resync_and_buffer();
        test_done();
    end
endmodule

// ==== verification/framer_model.sv ====
// Behavioural framer: sinks the transmit stream and loops it back as the
// receive stream, so with zero data and flip low every inverted bit shows up as one received error.
module framer_model
(
    input  wire logic clk,
    input  wire logic stall,
    input  wire logic flip,
    input  wire logic tx_valid,
    input  wire logic tx_bit,
    output logic      tx_ready,
    output logic      rx_valid,
    output logic      rx_bit,
    output logic      rx_expected,
    output int        ones,
    output int        bits
);
    timeunit 1ns;
    timeprecision 1ps;

    logic idle_tgl = 1'b0;  // Filler driven on the data line between bits

    // Stall holds the head bit in the block's buffer
    assign tx_ready    = ~stall;
    assign rx_valid    = tx_valid & tx_ready;
    // Never show a stale bit while idle: a settled unknown could hide faults
    assign rx_bit      = rx_valid ? tx_bit : idle_tgl;
    // Expected pattern is all zeros; flip makes every bit a mismatch
    assign rx_expected = flip;

    initial
    begin
        ones = 0;
        bits = 0;
    end

    // Count delivered bits and ones (inserted errors, as data is zero)
    always @(posedge clk)
    begin
        idle_tgl <= ~idle_tgl;
        if (rx_valid === 1'b1)
        begin
            bits <= bits + 1;
            ones <= ones + int'(tx_bit);
        end
    end
endmodule
